// ### hw/ipmc_pkg.sv
// package for the indirect pin mode configuration block
// assumes a classic wishbone slave with 32-bit data and byte addresses
package ipmc_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] IPMC_P2_IDX = 8'h97;
    localparam logic [7:0] IPMC_P3_IDX = 8'h8f;
    localparam int IPMC_ADDR_W = 10;
    localparam logic [IPMC_ADDR_W-1:0] IPMC_P2_ADDR = {IPMC_P2_IDX, 2'b00};
    localparam logic [IPMC_ADDR_W-1:0] IPMC_P3_ADDR = {IPMC_P3_IDX, 2'b00};
    // control byte layout
    localparam int IPMC_MODE_HI = 7;
    localparam int IPMC_MODE_LO = 5;
    localparam int IPMC_DIR_BIT = 4;
    localparam int IPMC_LATCH_BIT = 3;
    localparam int IPMC_IDX_HI = 2;
    localparam int IPMC_IDX_LO = 0;
    // reset values
    localparam logic [7:0] IPMC_CTRL_RST = 8'h00;
    localparam logic [2:0] IPMC_OUT_RST = 3'h0;
    localparam logic [1:0] IPMC_IN_RST = 2'h0;
    // mode codes
    localparam logic [2:0] IPMC_OUT_NORMAL = 3'h0;
    localparam logic [2:0] IPMC_OUT_HIGH = 3'h3;
    localparam logic [1:0] IPMC_IN_NOPULL = 2'h0;
    localparam logic [1:0] IPMC_IN_PULLDN = 2'h1;
    localparam logic [1:0] IPMC_IN_PULLUP = 2'h2;
    localparam logic [1:0] IPMC_IN_OFF = 2'h3;
    localparam logic [2:0] IPMC_P3_RSVD_IDX = 3'h7;
endpackage

// ### hw/ipmc_pin_mode.sv
// indirect per-pin mode configuration for port 2 and port 3
// assumes a classic wishbone master on mclk; pin pads sit outside
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// R01 - non-latch write sets one pin's mode
// R02 - output codes: 000 normal, 011 high drive
// R03 - input mode uses low two bits
// R04 - input codes: nopull, pulldown, pullup, off
// R05 - read returns latched pin's current mode
// R06 - bit 4 picks output or input
// R07 - latch flag stores index, modes unchanged
// R08 - latch clear overwrites addressed pin mode
// R09 - port 2 index 0..7 maps pins 0..7
// R10 - port 3 register covers pins 0..6
// R11 - port 3 index 7 reserved, unmapped
// R12 - reset latch reads pin 0 output
module ipmc_pin_mode
    import ipmc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [IPMC_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic [23:0] p2OutMode,
    output logic [15:0] p2InMode,
    output logic [7:0] p2InBufOn,
    output logic [7:0] p2PullDn,
    output logic [7:0] p2PullUp,
    output logic [7:0] p2HighDrive,
    output logic [20:0] p3OutMode,
    output logic [13:0] p3InMode,
    output logic [6:0] p3InBufOn,
    output logic [6:0] p3PullDn,
    output logic [6:0] p3PullUp,
    output logic [6:0] p3HighDrive
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic req;
    logic hitP2;
    logic hitP3;
    logic wrByte;
    logic [7:0] wrData;
    logic [2:0] wrMode;
    logic [2:0] wrIdx;
    logic wrDir;
    logic wrLatch;

    // single-cycle ack; the pulse also masks the request for the cycle after
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wrData = wb_dat_i[7:0];
    assign wrByte = wb_sel_i[0];
    assign wrMode = wrData[IPMC_MODE_HI:IPMC_MODE_LO];
    assign wrIdx = wrData[IPMC_IDX_HI:IPMC_IDX_LO];
    assign wrDir = wrData[IPMC_DIR_BIT];
    assign wrLatch = wrData[IPMC_LATCH_BIT];

    always_comb begin
        hitP2 = 1'b0;
        hitP3 = 1'b0;
        if (wb_adr_i == IPMC_P2_ADDR) begin
            hitP2 = 1'b1;
        end else if (wb_adr_i == IPMC_P3_ADDR) begin
            hitP3 = 1'b1;
        end
    end

    logic p2Wr;
    logic p3Wr;
    assign p2Wr = req && wb_we_i && hitP2 && wrByte;
    assign p3Wr = req && wb_we_i && hitP3 && wrByte;

    // latch writes only move the read pointer, mode writes only touch storage
    logic p2LatchWr;
    logic p3LatchWr;
    logic p2ModeWr;
    logic p3ModeWr;
    assign p2LatchWr = p2Wr && wrLatch;
    assign p3LatchWr = p3Wr && wrLatch;
    assign p2ModeWr = p2Wr && !wrLatch; // R01 R08
    // port 3 has no pin behind index 7, so such a write is dropped
    assign p3ModeWr = p3Wr && !wrLatch && wrIdx != IPMC_P3_RSVD_IDX; // R11

    ////////////////////////////////////////////////////////////////////////////
    // read latches
    logic [2:0] p2RdIdx_ff;
    logic p2RdDir_ff;
    logic [2:0] p3RdIdx_ff;
    logic p3RdDir_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p2RdIdx_ff <= 3'h0; // R12
            p2RdDir_ff <= 1'b0; // R12
        end else if (p2LatchWr) begin // R07
            p2RdIdx_ff <= wrIdx;
            p2RdDir_ff <= wrDir;
        end
    end

    // port 3 keeps its own pointer; a latched index 7 is legal but reads zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p3RdIdx_ff <= 3'h0; // R12
            p3RdDir_ff <= 1'b0; // R12
        end else if (p3LatchWr) begin // R07
            p3RdIdx_ff <= wrIdx;
            p3RdDir_ff <= wrDir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode storage, one output and one input code per pin
    logic [2:0] p2Out_ff [8];
    logic [1:0] p2In_ff [8];
    logic [2:0] p3Out_ff [7];
    logic [1:0] p3In_ff [7];

    // every index maps a pin on port 2
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                p2Out_ff[i] <= IPMC_OUT_RST;
            end
        end else if (p2ModeWr && !wrDir) begin // R01 R06
            p2Out_ff[wrIdx] <= wrMode; // R02 R09
        end
    end

    // only two bits are kept for input; bit 7 of the field is dropped
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++) begin
                p2In_ff[i] <= IPMC_IN_RST;
            end
        end else if (p2ModeWr && wrDir) begin // R01 R06
            p2In_ff[wrIdx] <= wrMode[1:0]; // R03 R09
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < 7; i++) begin
                p3Out_ff[i] <= IPMC_OUT_RST;
            end
        end else if (p3ModeWr && !wrDir) begin // R06 R10
            p3Out_ff[wrIdx] <= wrMode; // R02
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < 7; i++) begin
                p3In_ff[i] <= IPMC_IN_RST;
            end
        end else if (p3ModeWr && wrDir) begin // R06 R10
            p3In_ff[wrIdx] <= wrMode[1:0]; // R03
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path and ack
    logic [2:0] p2RdMode;
    logic [2:0] p3RdMode;
    logic [7:0] nxt_rdByte;

    always_comb begin
        if (p2RdDir_ff) begin // R05
            p2RdMode = {1'b0, p2In_ff[p2RdIdx_ff]};
        end else begin
            p2RdMode = p2Out_ff[p2RdIdx_ff];
        end
        // reserved index reads as zero
        if (p3RdIdx_ff == IPMC_P3_RSVD_IDX) begin // R11
            p3RdMode = 3'h0;
        end else if (p3RdDir_ff) begin
            p3RdMode = {1'b0, p3In_ff[p3RdIdx_ff]};
        end else begin
            p3RdMode = p3Out_ff[p3RdIdx_ff];
        end
        nxt_rdByte = IPMC_CTRL_RST;
        if (hitP2) begin
            nxt_rdByte = {p2RdMode, 5'h00}; // R05
        end else if (hitP3) begin
            nxt_rdByte = {p3RdMode, 5'h00}; // R05
        end
    end

    // unmapped addresses are answered with err so a stray access never hangs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req && (hitP2 || hitP3);
            wb_err_o <= req && !(hitP2 || hitP3);
        end
    end

    // read data holds until the next read is taken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {24'h0, nxt_rdByte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded pad controls, registered
    // pads see every change one cycle after the write is taken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p2OutMode <= 24'h0;
            p2InMode <= 16'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                p2OutMode[i*3 +: 3] <= p2Out_ff[i];
                p2InMode[i*2 +: 2] <= p2In_ff[i];
            end
        end
    end

    // code 11 parks the input buffer with no pull attached
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p2InBufOn <= 8'hff;
            p2PullDn <= 8'h0;
            p2PullUp <= 8'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                p2InBufOn[i] <= p2In_ff[i] != IPMC_IN_OFF; // R04
                p2PullDn[i] <= p2In_ff[i] == IPMC_IN_PULLDN; // R04
                p2PullUp[i] <= p2In_ff[i] == IPMC_IN_PULLUP; // R04
            end
        end
    end

    // illegal output codes are kept but give normal drive
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p2HighDrive <= 8'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                p2HighDrive[i] <= p2Out_ff[i] == IPMC_OUT_HIGH; // R02
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p3OutMode <= 21'h0;
            p3InMode <= 14'h0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                p3OutMode[i*3 +: 3] <= p3Out_ff[i];
                p3InMode[i*2 +: 2] <= p3In_ff[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p3InBufOn <= 7'h7f;
            p3PullDn <= 7'h0;
            p3PullUp <= 7'h0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                p3InBufOn[i] <= p3In_ff[i] != IPMC_IN_OFF; // R04
                p3PullDn[i] <= p3In_ff[i] == IPMC_IN_PULLDN; // R04
                p3PullUp[i] <= p3In_ff[i] == IPMC_IN_PULLUP; // R04
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p3HighDrive <= 7'h0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                p3HighDrive[i] <= p3Out_ff[i] == IPMC_OUT_HIGH; // R02
            end
        end
    end

endmodule

`default_nettype wire

// ### verif/ipmc_chk.sv
// concurrent checks on the pin mode block ports
// assumes a single mclk domain, bound onto ipmc_pin_mode
`timescale 1ns/1ns
`default_nettype none
module ipmc_chk
    import ipmc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [IPMC_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [23:0] p2OutMode,
    input wire logic [15:0] p2InMode,
    input wire logic [7:0] p2InBufOn,
    input wire logic [7:0] p2PullDn,
    input wire logic [20:0] p3OutMode,
    input wire logic [13:0] p3InMode,
    input wire logic [6:0] p3PullUp
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a request is new only while no answer is showing
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_sel_i[0];
    wire logic wr2 = req && wb_we_i && wb_adr_i == IPMC_P2_ADDR;
    wire logic wr3 = req && wb_we_i && wb_adr_i == IPMC_P3_ADDR;
    ////////////////////////////////////////
    a_ack_next: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered once");
    a_rd_low: assert property (req && !wb_we_i |=> wb_dat_o[4:0] == 5'h0)
        else $error("read data low bits set");
    a_out_wr: assert property (wr2 && wb_dat_i[4:3] == 2'h0 |-> ##2
        p2OutMode[3*$past(wb_dat_i[2:0], 2) +: 3] == $past(wb_dat_i[7:5], 2))
        else $error("output mode not applied");
    a_in_wr: assert property (wr2 && wb_dat_i[4:3] == 2'h2 |-> ##2
        p2InMode[2*$past(wb_dat_i[2:0], 2) +: 2] == $past(wb_dat_i[6:5], 2))
        else $error("input mode not applied");
    a_latch_keep: assert property (wr2 && wb_dat_i[3] |-> ##2
        p2OutMode == $past(p2OutMode, 2) && p2InMode == $past(p2InMode, 2))
        else $error("latch write changed a mode");
    a_p3_rsvd: assert property (wr3 && !wb_dat_i[3] && wb_dat_i[2:0] == 3'h7 |-> ##2
        p3OutMode == $past(p3OutMode, 2) && p3InMode == $past(p3InMode, 2))
        else $error("reserved port 3 pin changed a mode");
    a_buf_dec: assert property (p2InBufOn[0] == (p2InMode[1:0] != 2'h3))
        else $error("input buffer decode wrong");
    a_pull_dec: assert property (p2PullDn[7] == (p2InMode[15:14] == 2'h1)
        && p3PullUp[6] == (p3InMode[13:12] == 2'h2)) else $error("pull decode wrong");
endmodule
bind ipmc_pin_mode ipmc_chk ipmc_chk_i(.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .p2OutMode,
    .p2InMode, .p2InBufOn, .p2PullDn, .p3OutMode, .p3InMode, .p3PullUp);
`default_nettype wire

// ### verif/ipmc_pin_mode_tb.sv
// self-checking bench for the pin mode block
// assumes the bench is the only wishbone master
`timescale 1ns/1ns
`default_nettype none
module ipmc_pin_mode_tb import ipmc_pkg::*; ;
    logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, err, e;
    logic [9:0] adr = 0;
    logic [31:0] dat = 0, dout, rd, r = 32'hc614;
    logic [23:0] o2;
    logic [15:0] i2;
    logic [7:0] b2, h2, d, pd2, pu2;
    logic [20:0] o3;
    logic [13:0] i3;
    logic [6:0] b3, pd3, pu3, h3;
    logic [2:0] om[2][8], li[2];
    logic [1:0] im[2][8];
    logic ld[2];
    int fail_count = 0, checks = 0;
    always #10 mclk = ~mclk;
    ipmc_pin_mode ipmc_pin_mode_i(.mclk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dout), .wb_ack_o(ack),
        .wb_err_o(err), .p2OutMode(o2), .p2InMode(i2), .p2InBufOn(b2), .p2PullDn(pd2),
        .p2PullUp(pu2), .p2HighDrive(h2), .p3OutMode(o3), .p3InMode(i3), .p3InBufOn(b3),
        .p3PullDn(pd3), .p3PullUp(pu3), .p3HighDrive(h3));
    ////////////////////////////////////////
    function logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task finish_test;
        if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task clr;
        for (int i = 0; i < 16; i++) begin
            om[i / 8][i % 8] = 3'h0;
            im[i / 8][i % 8] = 2'h0;
        end
        li = '{3'h0, 3'h0};
        ld = '{1'b0, 1'b0};
    endtask
    task wb(input logic w, input logic [9:0] a, input logic [7:0] v);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, v};
        do begin
            @(posedge mclk);
        end while (!(ack | err));
        chk("answer", 32'h1, {31'h0, ack | err});
        e = err;
        rd = dout;
        cyc <= 0;
        stb <= 0;
        @(posedge mclk);
    endtask
    task put(input logic q, input logic [7:0] v);
        wb(1, q ? IPMC_P3_ADDR : IPMC_P2_ADDR, v);
        if (v[3]) begin
            li[q] = v[2:0];
            ld[q] = v[4];
        end else if (!(q && v[2:0] == IPMC_P3_RSVD_IDX)) begin
            if (v[4]) im[q][v[2:0]] = v[6:5];
            else om[q][v[2:0]] = v[7:5];
        end
    endtask
    task get(input logic q);
        wb(0, q ? IPMC_P3_ADDR : IPMC_P2_ADDR, 8'h0);
        chk("readback", {24'h0, ld[q] ? {1'b0, im[q][li[q]]} : om[q][li[q]], 5'h0}, rd);
    endtask
    task pads;
        logic [23:0] eo;
        logic [15:0] ei;
        logic [7:0] eb, eh, ed, eu;
        logic [20:0] fo;
        logic [13:0] fi;
        logic [6:0] fb, fd, fu, fh;
        for (int i = 0; i < 8; i++) begin
            eo[3*i +: 3] = om[0][i];
            ei[2*i +: 2] = im[0][i];
            eb[i] = im[0][i] != IPMC_IN_OFF;
            eh[i] = om[0][i] == IPMC_OUT_HIGH;
            ed[i] = im[0][i] == IPMC_IN_PULLDN;
            eu[i] = im[0][i] == IPMC_IN_PULLUP;
            if (i < 7) begin
                fo[3*i +: 3] = om[1][i];
                fi[2*i +: 2] = im[1][i];
                fb[i] = im[1][i] != IPMC_IN_OFF;
                fd[i] = im[1][i] == IPMC_IN_PULLDN;
                fu[i] = im[1][i] == IPMC_IN_PULLUP;
                fh[i] = om[1][i] == IPMC_OUT_HIGH;
            end
        end
        chk("p2PullDn", {24'h0, ed}, {24'h0, pd2});
        chk("p2PullUp", {24'h0, eu}, {24'h0, pu2});
        chk("p3InMode", {18'h0, fi}, {18'h0, i3});
        chk("p3InBufOn", {25'h0, fb}, {25'h0, b3});
        chk("p3PullDn", {25'h0, fd}, {25'h0, pd3});
        chk("p3PullUp", {25'h0, fu}, {25'h0, pu3});
        chk("p3HighDrive", {25'h0, fh}, {25'h0, h3});
        chk("p2OutMode", {8'h0, eo}, {8'h0, o2});
        chk("p2InMode", {16'h0, ei}, {16'h0, i2});
        chk("p2InBufOn", {24'h0, eb}, {24'h0, b2});
        chk("p2HighDrive", {24'h0, eh}, {24'h0, h2});
        chk("p3OutMode", {11'h0, fo}, {11'h0, o3});
    endtask
    initial begin
        clr;
        repeat (5) @(posedge mclk);
        rst_n <= 1;
        @(posedge mclk);
        get(0);
        pads;
        wb(1, 10'h004, 8'h68);
        chk("unmapped err", 32'h1, {31'h0, e});
        for (int c = 0; c < 4; c++) begin
            put(0, {1'b0, c[1:0], 5'h17});
            put(0, 8'h1f);
            get(0);
            pads;
        end
        repeat (300) begin
            r = lfsr(r);
            d = r[15:8];
            // software only writes the two legal output codes
            if (d[4:3] == 2'h0) d[7:5] = {1'b0, d[7], d[7]};
            put(r[0], d);
            get(r[0]);
        end
        pads;
        // reset in mid-run must clear modes and the read pointers
        rst_n <= 0;
        repeat (2) @(posedge mclk);
        rst_n <= 1;
        clr;
        @(posedge mclk);
        pads;
        get(1);
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        finish_test;
    end
endmodule
`default_nettype wire
